/* verilog/sieb_irq_enable_bank.sv */
/*
 * interrupt-enable and channel-monitor-enable register group of a
 * multichannel supervisor. holds the masks, reads them back, and drives
 * the active-low open-drain fault interrupt pin from enabled fault levels.
 * assumes the serial front end decodes transfers into single-cycle
 * read and write strobes on clk_i, and that fault sources are held levels
 * produced on the same clock.
 */
module sieb_irq_enable_bank
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // register access port
    input wire logic [sieb_pkg::SIEB_ADDR_W-1:0] reg_addr_i,
    input wire logic [sieb_pkg::SIEB_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [sieb_pkg::SIEB_DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // fault sources, held levels
    input wire logic [sieb_pkg::SIEB_SEQ_CH-1:0] seq_off_fault_i,
    input wire logic [sieb_pkg::SIEB_SEQ_CH-1:0] seq_exs_fault_i,
    input wire logic [sieb_pkg::SIEB_SEQ_CH-1:0] seq_ens_fault_i,
    input wire logic rt_crc_fault_i,
    input wire logic tsd_fault_i,
    input wire logic sync_fault_i,
    input wire logic pec_fault_i,
    input wire logic otp_correct_fault_i,
    input wire logic bist_done_i,
    input wire logic bist_fail_i,
    // channel monitor enables
    output logic [sieb_pkg::SIEB_MON_CH-1:0] mon_chan_en_o,
    // open-drain interrupt pin
    output logic fault_irq_out_n_o,
    output logic fault_irq_oe_o
);
    import sieb_pkg::*;

    // ==================================================================
    // mask registers
    logic [7:0] seq_off_mask_reg;
    logic [7:0] seq_exs_mask_reg;
    logic [7:0] seq_ens_mask_reg;
    logic [7:0] ctrl_mask_reg;
    logic [7:0] test_mask_reg;
    logic [7:0] mon_en_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic irq_reg;
    logic irq_next;
    logic [7:0] ctrl_src;
    logic [7:0] test_src;

    // only implemented bits ever store a one, so reserved bits read zero
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            seq_off_mask_reg <= SIEB_RST_SEQ;
            seq_exs_mask_reg <= SIEB_RST_SEQ;
            seq_ens_mask_reg <= SIEB_RST_SEQ;
            ctrl_mask_reg <= SIEB_RST_CTRL;
            test_mask_reg <= SIEB_RST_TEST;
            mon_en_reg <= SIEB_RST_MON;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                SIEB_OFF_SEQ_OFF: seq_off_mask_reg <= reg_wdata_i & SIEB_MASK_SEQ;
                SIEB_OFF_SEQ_EXS: seq_exs_mask_reg <= reg_wdata_i & SIEB_MASK_SEQ;
                SIEB_OFF_SEQ_ENS: seq_ens_mask_reg <= reg_wdata_i & SIEB_MASK_SEQ;
                SIEB_OFF_CTRL: ctrl_mask_reg <= reg_wdata_i & SIEB_MASK_CTRL;
                SIEB_OFF_TEST: test_mask_reg <= reg_wdata_i & SIEB_MASK_TEST;
                SIEB_OFF_MON_EN: mon_en_reg <= reg_wdata_i & SIEB_MASK_MON;
                // maker register and unmapped offsets drop the write
                default: ;
            endcase
        end
    end

    // ==================================================================
    // read back
    always_comb
    begin
        unique case (reg_addr_i)
            SIEB_OFF_SEQ_OFF: rdata_next = seq_off_mask_reg;
            SIEB_OFF_SEQ_EXS: rdata_next = seq_exs_mask_reg;
            SIEB_OFF_SEQ_ENS: rdata_next = seq_ens_mask_reg;
            SIEB_OFF_CTRL: rdata_next = ctrl_mask_reg;
            SIEB_OFF_TEST: rdata_next = test_mask_reg;
            SIEB_OFF_MON_EN: rdata_next = mon_en_reg;
            default: rdata_next = SIEB_RD_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_reg <= SIEB_RD_ZERO;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= reg_rd_i;
            if (reg_rd_i)
            begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;
    assign mon_chan_en_o = mon_en_reg;

    // ==================================================================
    // interrupt gating
    always_comb
    begin
        ctrl_src = SIEB_RD_ZERO;
        ctrl_src[SIEB_BIT_RT_CRC] = rt_crc_fault_i;
        ctrl_src[SIEB_BIT_TSD] = tsd_fault_i;
        ctrl_src[SIEB_BIT_SYNC] = sync_fault_i;
        ctrl_src[SIEB_BIT_PEC] = pec_fault_i;
        test_src = SIEB_RD_ZERO;
        test_src[SIEB_BIT_OTP_CORRECT] = otp_correct_fault_i;
        test_src[SIEB_BIT_BIST_DONE] = bist_done_i;
        test_src[SIEB_BIT_BIST_FAIL] = bist_fail_i;
    end

    // a zero enable bit blocks its source outright; reserved mask bits
    // are always zero so unused source slots can never assert the pin
    assign irq_next = (|(seq_off_fault_i & seq_off_mask_reg[SIEB_SEQ_CH-1:0]))
        | (|(seq_exs_fault_i & seq_exs_mask_reg[SIEB_SEQ_CH-1:0]))
        | (|(seq_ens_fault_i & seq_ens_mask_reg[SIEB_SEQ_CH-1:0]))
        | (|(ctrl_src & ctrl_mask_reg))
        | (|(test_src & test_mask_reg));

    // registered so the pin never glitches on a combinational hazard
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next;
        end
    end

    // open drain: pull low while an enabled fault is pending
    assign fault_irq_out_n_o = ~irq_reg;
    assign fault_irq_oe_o = irq_reg;

    // ==================================================================
    // assertions
    sequence s_write(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence

    sequence s_read(logic [7:0] a);
        reg_rd_i && reg_addr_i == a && !reg_wr_i;
    endsequence

    // write, one idle cycle, then read back the same offset; the idle cycle
    // keeps a second write from muddling the byte that is expected back
    sequence s_write_read(logic [7:0] a);
        s_write(a) ##1 !reg_wr_i ##1 s_read(a);
    endsequence

    property p_seq_off;
        @(posedge clk_i) disable iff (!resetn_i)
        (|(seq_off_fault_i & seq_off_mask_reg[SIEB_SEQ_CH-1:0])) |=> !fault_irq_out_n_o;
    endproperty
    a_seq_off: assert property (p_seq_off) else $error("power-off fault not raised");

    property p_seq_off_write;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write_read(SIEB_OFF_SEQ_OFF)
            |=> reg_rdata_o == ($past(reg_wdata_i, 3) & SIEB_MASK_SEQ);
    endproperty
    a_seq_off_write: assert property (p_seq_off_write) else $error("off mask readback");

    property p_seq_exs_write;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write_read(SIEB_OFF_SEQ_EXS)
            |=> reg_rdata_o == ($past(reg_wdata_i, 3) & SIEB_MASK_SEQ);
    endproperty
    a_seq_exs_write: assert property (p_seq_exs_write) else $error("exit mask read");

    property p_seq_ens_write;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write_read(SIEB_OFF_SEQ_ENS)
            |=> reg_rdata_o == ($past(reg_wdata_i, 3) & SIEB_MASK_SEQ);
    endproperty
    a_seq_ens_write: assert property (p_seq_ens_write) else $error("entry mask read");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write_read(SIEB_OFF_CTRL)
            |=> reg_rdata_o == ($past(reg_wdata_i, 3) & SIEB_MASK_CTRL);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control mask read");

    property p_test_write;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write_read(SIEB_OFF_TEST)
            |=> reg_rdata_o == ($past(reg_wdata_i, 3) & SIEB_MASK_TEST);
    endproperty
    a_test_write: assert property (p_test_write) else $error("test mask read");

    property p_seq_exs;
        @(posedge clk_i) disable iff (!resetn_i)
        (|(seq_exs_fault_i & seq_exs_mask_reg[SIEB_SEQ_CH-1:0])) |=> fault_irq_oe_o;
    endproperty
    a_seq_exs: assert property (p_seq_exs) else $error("sleep-exit fault not raised");

    property p_seq_ens;
        @(posedge clk_i) disable iff (!resetn_i)
        (|(seq_ens_fault_i & seq_ens_mask_reg[SIEB_SEQ_CH-1:0])) |=> !fault_irq_out_n_o;
    endproperty
    a_seq_ens: assert property (p_seq_ens) else $error("sleep-entry fault not raised");

    property p_rt_crc;
        @(posedge clk_i) disable iff (!resetn_i)
        rt_crc_fault_i && ctrl_mask_reg[SIEB_BIT_RT_CRC] |=> !fault_irq_out_n_o;
    endproperty
    a_rt_crc: assert property (p_rt_crc) else $error("checksum fault not raised");

    property p_tsd;
        @(posedge clk_i) disable iff (!resetn_i)
        tsd_fault_i && ctrl_mask_reg[SIEB_BIT_TSD] |=> !fault_irq_out_n_o;
    endproperty
    a_tsd: assert property (p_tsd) else $error("thermal fault not raised");

    property p_sync;
        @(posedge clk_i) disable iff (!resetn_i)
        sync_fault_i && ctrl_mask_reg[SIEB_BIT_SYNC] |=> !fault_irq_out_n_o;
    endproperty
    a_sync: assert property (p_sync) else $error("tag pin fault not raised");

    property p_pec;
        @(posedge clk_i) disable iff (!resetn_i)
        pec_fault_i && ctrl_mask_reg[SIEB_BIT_PEC] |=> !fault_irq_out_n_o;
    endproperty
    a_pec: assert property (p_pec) else $error("packet check fault not raised");

    property p_ecc;
        @(posedge clk_i) disable iff (!resetn_i)
        otp_correct_fault_i && test_mask_reg[SIEB_BIT_OTP_CORRECT] |=> !fault_irq_out_n_o;
    endproperty
    a_ecc: assert property (p_ecc) else $error("corrected error not raised");

    property p_bist_done;
        @(posedge clk_i) disable iff (!resetn_i)
        bist_done_i && test_mask_reg[SIEB_BIT_BIST_DONE] |=> !fault_irq_out_n_o;
    endproperty
    a_bist_done: assert property (p_bist_done) else $error("self-test done not raised");

    property p_bist_fail_off;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write(SIEB_OFF_TEST) ##0 !reg_wdata_i[SIEB_BIT_BIST_FAIL]
            |=> !test_mask_reg[SIEB_BIT_BIST_FAIL];
    endproperty
    a_bist_fail_off: assert property (p_bist_fail_off) else $error("fail enable stuck");

    property p_mon_en;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write(SIEB_OFF_MON_EN) |=> mon_chan_en_o == $past(reg_wdata_i);
    endproperty
    a_mon_en: assert property (p_mon_en) else $error("monitor enable not stored");

    property p_vendor;
        @(posedge clk_i) disable iff (!resetn_i)
        s_read(SIEB_OFF_VENDOR) |=> reg_rvalid_o && reg_rdata_o == SIEB_RD_ZERO;
    endproperty
    a_vendor: assert property (p_vendor) else $error("maker register not zero");

    // a write to the maker register must leave every real mask untouched
    property p_vendor_write;
        @(posedge clk_i) disable iff (!resetn_i)
        s_write(SIEB_OFF_VENDOR) |=> $stable(seq_off_mask_reg) && $stable(seq_exs_mask_reg)
            && $stable(seq_ens_mask_reg) && $stable(ctrl_mask_reg)
            && $stable(test_mask_reg) && $stable(mon_en_reg);
    endproperty
    a_vendor_write: assert property (p_vendor_write) else $error("maker write leaked");

    property p_rvalid_pulse;
        @(posedge clk_i) disable iff (!resetn_i)
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

    property p_rvalid_idle;
        @(posedge clk_i) disable iff (!resetn_i)
        !reg_rd_i |=> !reg_rvalid_o;
    endproperty
    a_rvalid_idle: assert property (p_rvalid_idle) else $error("stray read valid");

    // read data is held between reads so a slow front end may pick it up late
    property p_rdata_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        !reg_rd_i |=> $stable(reg_rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    property p_mon_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        !reg_wr_i |=> $stable(mon_chan_en_o);
    endproperty
    a_mon_hold: assert property (p_mon_hold) else $error("monitor enable moved");

    property p_quiet;
        @(posedge clk_i) disable iff (!resetn_i)
        !(|(seq_off_fault_i & seq_off_mask_reg[SIEB_SEQ_CH-1:0]))
        && !(|(seq_exs_fault_i & seq_exs_mask_reg[SIEB_SEQ_CH-1:0]))
        && !(|(seq_ens_fault_i & seq_ens_mask_reg[SIEB_SEQ_CH-1:0]))
        && !(|(ctrl_src & ctrl_mask_reg)) && !(|(test_src & test_mask_reg))
            |=> fault_irq_out_n_o && !fault_irq_oe_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pin asserted with no enabled fault");

    property p_reserved;
        @(posedge clk_i) disable iff (!resetn_i)
        reg_wr_i |=> (seq_off_mask_reg & ~SIEB_MASK_SEQ) == SIEB_RD_ZERO
            && (seq_exs_mask_reg & ~SIEB_MASK_SEQ) == SIEB_RD_ZERO
            && (seq_ens_mask_reg & ~SIEB_MASK_SEQ) == SIEB_RD_ZERO
            && (ctrl_mask_reg & ~SIEB_MASK_CTRL) == SIEB_RD_ZERO
            && (test_mask_reg & ~SIEB_MASK_TEST) == SIEB_RD_ZERO;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule

/* pkg/sieb_pkg.sv */
/*
 * shared constants for the supervisor interrupt-enable bank: register
 * offsets, implemented-bit masks, field positions and reset values.
 * assumes an 8-bit register access port with byte offsets as printed.
 */
package sieb_pkg;

    // ==================================================================
    // widths
    localparam int SIEB_DATA_W = 8;
    localparam int SIEB_ADDR_W = 8;
    localparam int SIEB_SEQ_CH = 6;
    localparam int SIEB_MON_CH = 8;

    // ==================================================================
    // register offsets
    localparam logic [7:0] SIEB_OFF_SEQ_OFF = 8'h18;
    localparam logic [7:0] SIEB_OFF_SEQ_EXS = 8'h19;
    localparam logic [7:0] SIEB_OFF_SEQ_ENS = 8'h1A;
    localparam logic [7:0] SIEB_OFF_CTRL = 8'h1B;
    localparam logic [7:0] SIEB_OFF_TEST = 8'h1C;
    localparam logic [7:0] SIEB_OFF_VENDOR = 8'h1D;
    localparam logic [7:0] SIEB_OFF_MON_EN = 8'h1E;

    // ==================================================================
    // writable-bit masks; reserved bits are zero here
    localparam logic [7:0] SIEB_MASK_SEQ = 8'h3F;
    localparam logic [7:0] SIEB_MASK_CTRL = 8'h17;
    localparam logic [7:0] SIEB_MASK_TEST = 8'h0B;
    localparam logic [7:0] SIEB_MASK_MON = 8'hFF;

    // ==================================================================
    // field positions
    localparam int SIEB_BIT_RT_CRC = 4;
    localparam int SIEB_BIT_TSD = 2;
    localparam int SIEB_BIT_SYNC = 1;
    localparam int SIEB_BIT_PEC = 0;
    localparam int SIEB_BIT_OTP_CORRECT = 3;
    localparam int SIEB_BIT_BIST_DONE = 1;
    localparam int SIEB_BIT_BIST_FAIL = 0;

    // ==================================================================
    // reset values
    localparam logic [7:0] SIEB_RST_SEQ = 8'h00;
    localparam logic [7:0] SIEB_RST_CTRL = 8'h00;
    localparam logic [7:0] SIEB_RST_TEST = 8'h00;
    localparam logic [7:0] SIEB_RST_MON = 8'h00;
    localparam logic [7:0] SIEB_RD_ZERO = 8'h00;

endpackage

/* tb/sieb_host_model.sv */
/*
 * host-side model of the register access port of the interrupt-enable bank.
 * assumes the bank takes one-cycle strobes on clk_i and answers reads one cycle later.
 */
module sieb_host_model
(
    // clock
    input wire logic clk_i,
    // requests toward the bank
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    // read answer
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // released lines show the inverse, so a stale value never passes for a live one
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
    endtask

    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(posedge clk_i);
        reg_addr_o <= addr;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        #1;
        vld = reg_rvalid_i;
        data = reg_rdata_i;
    endtask
endmodule

/* tb/sieb_irq_enable_bank_tb_top.sv */
/*
 * self-checking bench of the interrupt-enable bank: reset values, readback masks,
 * reserved places, and every fault source against its enable bit.
 * assumes the host model in tb/ and the package in pkg/.
 */
module sieb_irq_enable_bank_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sieb_pkg::*;

    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [24:0] flt = '0;
    logic [7:0] addr, wdata, rdata, mon;
    logic wr, rd, rvalid, irq_n, irq_oe;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    sieb_host_model sieb_host_model_inst (.clk_i(clk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid));

    sieb_irq_enable_bank sieb_irq_enable_bank_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .seq_off_fault_i(flt[5:0]),
        .seq_exs_fault_i(flt[11:6]), .seq_ens_fault_i(flt[17:12]),
        .rt_crc_fault_i(flt[18]), .tsd_fault_i(flt[19]), .sync_fault_i(flt[20]),
        .pec_fault_i(flt[21]), .otp_correct_fault_i(flt[22]), .bist_done_i(flt[23]),
        .bist_fail_i(flt[24]), .mon_chan_en_o(mon), .fault_irq_out_n_o(irq_n),
        .fault_irq_oe_o(irq_oe));

    // ==================================================================
    // checking helpers
    task automatic close_out();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        sieb_host_model_inst.rd_reg(a, d, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk($sformatf("reg %h", a), exp, d);
    endtask

    // pin state packed as {oe, out_n}; enabled fault gives 2'b10
    task automatic irq_chk(input logic on);
        repeat (2) @(posedge clk_i);
        #1;
        chk("irq pin", on ? 8'h02 : 8'h01, {6'h00, irq_oe, irq_n});
    endtask

    // readback of 0xFF: implemented bits only, reserved and unmapped read zero
    function automatic logic [7:0] ff_back(input logic [7:0] a);
        case (a)
            8'h18, 8'h19, 8'h1A: return 8'h3F;
            8'h1B: return 8'h17;
            8'h1C: return 8'h0B;
            8'h1E: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] src_bit(input int i);
        if (i < 18)
            return 8'h01 << (i % 6);
        case (i)
            18: return 8'h10;
            19: return 8'h04;
            20, 23: return 8'h02;
            22: return 8'h08;
            default: return 8'h01;
        endcase
    endfunction

    // ==================================================================
    // timeout
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            close_out();
        end
    end

    // ==================================================================
    // main sequence
    initial
    begin
        logic [7:0] a;
        logic [7:0] b;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        irq_chk(1'b0);
        for (int r = 8'h17; r <= 8'h1F; r++)
        begin
            a = r[7:0];
            rd_chk(a, 8'h00);
            sieb_host_model_inst.wr_reg(a, 8'hFF);
            rd_chk(a, ff_back(a));
            chk("mon", a == 8'h1E ? 8'hFF : 8'h00, mon);
            sieb_host_model_inst.wr_reg(a, 8'h00);
            rd_chk(a, 8'h00);
        end
        sieb_host_model_inst.wr_reg(SIEB_OFF_MON_EN, 8'hA5);
        @(posedge clk_i);
        chk("mon", 8'hA5, mon);
        resetn_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        chk("mon", 8'h00, mon);
        rd_chk(SIEB_OFF_MON_EN, 8'h00);
        for (int i = 0; i < 25; i++)
        begin
            a = (i < 18) ? 8'h18 + 8'(i / 6) : ((i < 22) ? 8'h1B : 8'h1C);
            b = src_bit(i);
            sieb_host_model_inst.wr_reg(a, ~b);
            @(posedge clk_i);
            flt <= 25'h1 << i;
            irq_chk(1'b0);
            sieb_host_model_inst.wr_reg(a, b);
            irq_chk(1'b1);
            @(posedge clk_i);
            flt <= '0;
            irq_chk(1'b0);
            sieb_host_model_inst.wr_reg(a, 8'h00);
        end
        sieb_host_model_inst.wr_reg(SIEB_OFF_TEST, 8'h01);
        rd_chk(SIEB_OFF_TEST, 8'h01);
        close_out();
    end
endmodule
